// ---- dv/fp_host_model.sv ----
`timescale 1ns/1ps
// host bus master: drives at falling edge, holds until ready has been seen
module fp_host_model
    import fp_issue_pkg::*;
(
    input  wire logic     clk,
    output bus_req_t      req,
    input  wire bus_rsp_t rsp
);
    initial req = '0;

    // one access; a request never answered is dropped after 60 cycles
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        q = '0;
        @(negedge clk);
        req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        while (!ok && n < 60) begin
            @(negedge clk);
            ok = rsp.ready;
            q = rsp.rdata;
            n++;
        end
        // keep valid through the ready-sampling edge, then release
        @(negedge clk);
        req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    endtask
endmodule // fp_host_model

// ---- dv/fp_issue_port_asserts.sv ----
`timescale 1ns/1ps
// bus-level checks on the issue port; sees only top-level ports
module fp_issue_port_asserts
    import fp_issue_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire bus_req_t   req,
    input wire bus_rsp_t   rsp,
    input wire logic [1:0] cmp_flags,
    input wire logic       undef_op
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic       in_win;
    logic [5:0] opc;
    // decode straight from the address lines, as the device must
    assign in_win = (req.addr >= WIN_BASE) && (req.addr <= WIN_LAST);
    assign opc    = req.addr[OPC_MSB:OPC_LSB];

    // first edge of each kind of access
    sequence s_store_req;
        $rose(req.valid) && !req.write && in_win && opc == OPC_STORE;
    endsequence
    sequence s_arith_wr;
        $rose(req.valid) && req.write && in_win && opc <= OPC_NEGMUL;
    endsequence
    sequence s_bad_read;
        $rose(req.valid) && !req.write && in_win && opc != OPC_STORE;
    endsequence

    a_ready_in_window: assert property (rsp.ready |-> $past(req.valid) && $past(in_win))
        else $error("ready without an in-window request");
    a_outside_quiet: assert property ($rose(req.valid) && !in_win |-> !rsp.ready [*8])
        else $error("out-of-window access answered");
    a_ready_one_cycle: assert property (rsp.ready |=> !rsp.ready)
        else $error("ready longer than one cycle");
    a_store_min_wait: assert property (s_store_req |-> !rsp.ready [*5])
        else $error("store answered too early");
    a_store_bounded: assert property (s_store_req |-> ##[5:60] rsp.ready)
        else $error("store never answered");
    a_write_acked: assert property (s_arith_wr |-> ##[1:40] rsp.ready)
        else $error("arithmetic write not acknowledged");
    a_idle_rdata_zero: assert property (!rsp.ready |-> rsp.rdata == 32'h0000_0000)
        else $error("read data outside a store answer");
    a_undef_on_read: assert property (s_bad_read |-> ##[1:4] undef_op)
        else $error("read of a non-store opcode not flagged");
    a_undef_sticky: assert property (undef_op |=> undef_op)
        else $error("undefined-opcode flag dropped");
endmodule // fp_issue_port_asserts

bind fp_issue_port fp_issue_port_asserts u_fp_issue_port_asserts (.clk(clk), .rst(rst),
    .req(req), .rsp(rsp), .cmp_flags(cmp_flags), .undef_op(undef_op));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import fp_issue_pkg::*;
;
    logic        clk;
    logic        rst;
    bus_req_t    req;
    bus_rsp_t    rsp;
    logic [1:0]  cmp_flags;
    logic        undef_op;
    logic [31:0] regs [32];
    logic [31:0] seed = 32'h0000_65B4;
    logic [5:0]  ops [4] = '{OPC_ABS, OPC_NEG, OPC_LOAD, OPC_ADD};
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;

    // free-running cycle count for the latency checks
    always @(posedge clk) cyc++;

    fp_issue_port u_fp_issue_port (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
        .cmp_flags(cmp_flags), .undef_op(undef_op));
    fp_host_model u_fp_host_model (.clk(clk), .req(req), .rsp(rsp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // exponent kept mid-range so a doubling stays exact under truncation
    function automatic logic [31:0] fval();
        logic [31:0] r;
        r = rnd();
        return {r[31], 2'b01, r[28:0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [31:0] iaddr(input logic [5:0] o, input int d, input int s);
        logic [31:0] a;
        a = WIN_BASE | {16'h0000, o, 10'h000};
        a[DST_MSB:DST_LSB] = d[4:0];
        a[SRC_HI_MSB:SRC_HI_LSB] = s[4:2];
        a[SRC_LO_MSB:SRC_LO_LSB] = s[1:0];
        return a;
    endfunction

    // one arithmetic write, reference updated at issue
    task automatic op(input logic [5:0] o, input int d, input int s, input logic [31:0] w);
        logic [31:0] v;
        logic [31:0] q;
        logic        ok;
        v = (s == 0) ? w : regs[s];
        u_fp_host_model.xfer(1'b1, iaddr(o, d, s), w, q, ok);
        check({31'h0, ok}, 32'h0000_0001);
        case (o)
            OPC_LOAD: regs[d] = v;
            OPC_ABS:  regs[d] = v & 32'h7FFF_FFFF;
            OPC_NEG:  regs[d] = v ^ 32'h8000_0000;
            OPC_CMP:  regs[d] = regs[d];
            // times 2.0, or plus an equal value: exponent goes up by one
            default:  regs[d] = regs[d] + 32'h0080_0000;
        endcase
    endtask

    task automatic st(input int d, input logic [31:0] e);
        logic [31:0] q;
        logic        ok;
        u_fp_host_model.xfer(1'b0, iaddr(OPC_STORE, d, 0), 32'h0000_0000, q, ok);
        check(ok ? q : ~e, e);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100_000;
        n_fail++;
        final_report();
    end

    initial begin
        logic [31:0] q;
        logic        ok;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < NREG; i++) st(i, FP_ZERO);
        // consecutive doubleword writes fill the whole file
        for (int i = 0; i < NREG; i++) op(OPC_LOAD, i, 0, fval());
        for (int i = 0; i < NREG; i++) st(i, regs[i]);
        for (int i = 11; i < 19; i++) op(OPC_MUL, i, 0, 32'h4000_0000);
        for (int i = 11; i < 19; i++) st(i, regs[i]);
        // abs, neg and load from the bus and from a register, add from the bus only; store right behind each
        for (int k = 0; k < 16; k++) begin
            int d;
            int t0;
            int lat;
            d = 1 + rnd() % 30;
            if (ops[k % 4] == OPC_ADD)
                op(OPC_ADD, d, 0, regs[d]);
            else
                op(ops[k % 4], d, (k < 8) ? 0 : d + 1, fval());
            // store drains the op, then counts its own three cycles; handshake adds one
            lat = (ops[k % 4] == OPC_ADD || ops[k % 4] == OPC_NEG) ? LAT_ADD : LAT_SHORT;
            t0 = cyc;
            st(d, regs[d]);
            check(32'(cyc - t0), 32'(lat + 4));
        end
        op(OPC_LOAD, 9, 0, 32'h0000_0000);
        st(9, FP_ZERO);
        // dependent ops issued back to back must wait for the writer
        op(OPC_MUL, 5, 0, 32'h4000_0000);
        op(OPC_LOAD, 6, 5, fval());
        op(OPC_NEG, 7, 6, fval());
        st(7, regs[7]);
        op(OPC_LOAD, 3, 0, 32'h3F80_0000);
        for (int k = 0; k < 2; k++) begin
            op(OPC_CMP, 3, 0, k ? 32'h4000_0000 : 32'h3F80_0000);
            st(3, regs[3]);
            check({30'h0, cmp_flags}, k ? 32'h0000_0002 : 32'h0000_0001);
        end
        // just outside the window on both sides: no answer, no effect
        u_fp_host_model.xfer(1'b1, WIN_LAST + 32'h1, fval(), q, ok);
        check({31'h0, ok}, 32'h0000_0000);
        u_fp_host_model.xfer(1'b1, WIN_BASE - 32'h4, fval(), q, ok);
        check({31'h0, ok}, 32'h0000_0000);
        st(0, regs[0]);
        st(31, regs[31]);
        check({31'h0, undef_op}, 32'h0000_0000);
        // a read of an arithmetic opcode is illegal and sticks
        u_fp_host_model.xfer(1'b0, iaddr(OPC_MUL, 1, 0), 32'h0000_0000, q, ok);
        repeat (2) @(negedge clk);
        check({31'h0, undef_op}, 32'h0000_0001);
        // mid-run reset clears the sticky flag and the register file
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check({31'h0, undef_op}, 32'h0000_0000);
        st(5, FP_ZERO);
        final_report();
    end
endmodule // tb_top

// ---- verilog/fp_alu.sv ----
`timescale 1ns/1ps
// single-precision add/subtract and multiply, truncating, denormals flush to zero
module fp_alu
    import fp_issue_pkg::*;
(
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    input  wire logic        sub,
    output logic      [31:0] sum,
    output logic      [31:0] prod
);
    logic [31:0] bb, big, sml;
    logic [7:0]  d;
    logic [23:0] mb, ms;
    logic [24:0] s;
    logic [9:0]  e, lz;
    logic [47:0] p;
    logic [9:0]  pe;

    // adder: order by magnitude so the difference never goes negative
    always_comb begin
        bb  = {b[31] ^ sub, b[30:0]};
        big = (a[30:0] < bb[30:0]) ? bb : a;
        sml = (a[30:0] < bb[30:0]) ? a : bb;
        d   = big[30:23] - sml[30:23];
        mb  = {|big[30:23], big[22:0]};
        ms  = (d > 8'h18) ? 24'h00_0000 : ({|sml[30:23], sml[22:0]} >> d);
        if (big[31] == sml[31]) begin
            s = {1'b0, mb} + {1'b0, ms};
        end else begin
            s = {1'b0, mb} - {1'b0, ms};
        end
        lz = 10'h000;
        for (int i = 0; i < 24; i++) begin
            if (s[i]) begin
                lz = 10'(23 - i);
            end
        end
        e = {2'h0, big[30:23]} - lz;
        if (s[24]) begin
            e   = {2'h0, big[30:23]} + 10'h001;
            sum = (e >= 10'h0FF) ? {big[31], 8'hFF, 23'h00_0000}
                                 : {big[31], e[7:0], s[23:1]};
        end else if (s == 25'h000_0000 || {2'h0, big[30:23]} <= lz) begin
            sum = FP_ZERO;
        end else begin
            sum = {big[31], e[7:0], 23'(s[23:0] << lz)};
        end
    end

    // multiplier: biased exponents add, bias removed once
    always_comb begin
        p  = {|a[30:23], a[22:0]} * {|b[30:23], b[22:0]};
        pe = {2'h0, a[30:23]} + {2'h0, b[30:23]} + {9'h000, p[47]};
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || pe <= 10'h07F) begin
            prod = {a[31] ^ b[31], 31'h0000_0000};
        end else if (pe >= 10'h17E) begin
            prod = {a[31] ^ b[31], 8'hFF, 23'h00_0000};
        end else begin
            prod = {a[31] ^ b[31], 8'(pe - 10'h07F), p[47] ? p[46:24] : p[45:23]};
        end
    end
endmodule // fp_alu

// ---- verilog/fp_issue_pkg.sv ----
package fp_issue_pkg;
    // instruction window on the host physical address bus
    localparam logic [31:0] WIN_BASE    = 32'hC000_0000;
    localparam logic [31:0] WIN_LAST    = 32'hC000_EFFF;
    // address field positions
    localparam int          DST_LSB     = 2;
    localparam int          DST_MSB     = 6;
    localparam int          SRC_LO_LSB  = 0;
    localparam int          SRC_LO_MSB  = 1;
    localparam int          SRC_HI_LSB  = 7;
    localparam int          SRC_HI_MSB  = 9;
    localparam int          OPC_LSB     = 10;
    localparam int          OPC_MSB     = 15;
    // opcode field values (add is fixed at zero, the rest are assigned here)
    localparam logic [5:0]  OPC_ADD     = 6'h00;
    localparam logic [5:0]  OPC_SUB     = 6'h01;
    localparam logic [5:0]  OPC_MUL     = 6'h02;
    localparam logic [5:0]  OPC_LOAD    = 6'h03;
    localparam logic [5:0]  OPC_ABS     = 6'h04;
    localparam logic [5:0]  OPC_NEG     = 6'h05;
    localparam logic [5:0]  OPC_CMP     = 6'h06;
    localparam logic [5:0]  OPC_ABSMUL  = 6'h07;
    localparam logic [5:0]  OPC_NEGMUL  = 6'h08;
    localparam logic [5:0]  OPC_STORE   = 6'h09;
    // register-to-register latencies in clock cycles
    localparam logic [3:0]  LAT_SHORT   = 4'h3;
    localparam logic [3:0]  LAT_ADD     = 4'h6;
    localparam logic [3:0]  LAT_MUL     = 4'h6;
    localparam logic [3:0]  LAT_ABSMUL  = 4'h9;
    localparam logic [3:0]  LAT_NEGMUL  = 4'hC;
    localparam logic [3:0]  LAT_STORE   = 4'h3;
    // storage sizes and reset values
    localparam int          NREG        = 32;
    localparam int          NSLOT       = 4;
    localparam logic [31:0] FP_ZERO     = 32'h0000_0000;
    localparam logic [1:0]  CMP_RESET   = 2'h0;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        is_cmp;
        logic [4:0]  dst;
        logic [3:0]  cnt;
        logic [31:0] res;
    } slot_t;
endpackage

// ---- verilog/fp_issue_port.sv ----
`timescale 1ns/1ps
// Operation
// - accesses inside instruction window only; others ignored
// - opcode and registers come from address only
// - address is opcode plus source plus destination
// - write data combined into destination register
// - each doubleword write is own instruction
// - thirty-two single-precision registers via destination field
// - loading all-zero word gives floating zero
// - latencies three, six, nine or twelve cycles per class
// - store waits until all operations finish
// - destination field sits at address bit two
// - source zero selects bus data word
module fp_issue_port
    import fp_issue_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire bus_req_t req,
    output bus_rsp_t      rsp,
    output logic [1:0]    cmp_flags,
    output logic          undef_op
);
    typedef enum logic [1:0] {S_IDLE, S_ACK, S_DRAIN, S_STORE} state_t;

    state_t      state_q, state_d;
    bus_rsp_t    rsp_q, rsp_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        undef_q, undef_d;
    logic [1:0]  cmp_q, cmp_d;
    slot_t       slot_q [NSLOT];
    slot_t       slot_d [NSLOT];
    logic [31:0] reg_q [NREG];
    logic [31:0] reg_d [NREG];

    logic        in_win, arith, reads_dst, hazard, free, idle_all, issue;
    logic [5:0]  opc;
    logic [4:0]  dst, src;
    logic [31:0] s_op, d_op, res, sum, prod;
    logic [3:0]  lat;
    logic [1:0]  free_idx;
    logic [NREG-1:0] busy;

    // address decode: the data lines never carry the opcode
    always_comb begin
        in_win = req.valid && req.addr >= WIN_BASE && req.addr <= WIN_LAST;
        opc    = req.addr[OPC_MSB:OPC_LSB];
        dst    = req.addr[DST_MSB:DST_LSB];
        src    = {req.addr[SRC_HI_MSB:SRC_HI_LSB], req.addr[SRC_LO_MSB:SRC_LO_LSB]};
        s_op   = (src == 5'h00) ? req.wdata : reg_q[src];
        d_op   = reg_q[dst];
    end

    fp_alu u_alu (
        .a    (d_op),
        .b    (s_op),
        .sub  (opc == OPC_SUB),
        .sum  (sum),
        .prod (prod)
    );

    // operation select: result, latency class and whether the destination is read
    always_comb begin
        arith     = 1'b1;
        reads_dst = 1'b1;
        res       = FP_ZERO;
        lat       = LAT_SHORT;
        case (opc)
            OPC_ADD, OPC_SUB: begin
                res = sum;
                lat = LAT_ADD;
            end
            OPC_MUL: begin
                res = prod;
                lat = LAT_MUL;
            end
            OPC_ABSMUL: begin
                res = {1'b0, prod[30:0]};
                lat = LAT_ABSMUL;
            end
            OPC_NEGMUL: begin
                res = {~prod[31], prod[30:0]};
                lat = LAT_NEGMUL;
            end
            OPC_LOAD: begin
                res       = s_op;
                reads_dst = 1'b0;
            end
            OPC_ABS: begin
                res       = {1'b0, s_op[30:0]};
                reads_dst = 1'b0;
            end
            OPC_NEG: begin
                res       = {~s_op[31], s_op[30:0]};
                reads_dst = 1'b0;
                lat       = LAT_ADD;
            end
            OPC_CMP: begin
                // bit 1: destination below source, bit 0: equal (signed zeros match)
                res[0] = (d_op == s_op) || ((d_op[30:0] | s_op[30:0]) == 31'h0);
                if (d_op[31] != s_op[31]) begin
                    res[1] = d_op[31] && !res[0];
                end else begin
                    res[1] = d_op[31] ? (d_op[30:0] > s_op[30:0])
                                      : (d_op[30:0] < s_op[30:0]);
                end
            end
            default: arith = 1'b0;
        endcase
    end

    // scoreboard: a register is busy while a slot will still write it
    always_comb begin
        busy     = '0;
        free     = 1'b0;
        free_idx = 2'h0;
        idle_all = 1'b1;
        for (int i = 0; i < NSLOT; i++) begin
            if (slot_q[i].valid && !slot_q[i].is_cmp) begin
                busy[slot_q[i].dst] = 1'b1;
            end
            if (!slot_q[i].valid) begin
                free     = 1'b1;
                free_idx = 2'(i); // exactly one slot takes an issue
            end
            if (slot_q[i].valid) begin
                idle_all = 1'b0;
            end
        end
        // compare reads its destination too, so the same check covers it
        hazard = (reads_dst && busy[dst]) || (src != 5'h00 && busy[src])
                 || (busy[dst] && opc != OPC_CMP);
    end

    // bus side: one instruction per access, held request released by ready
    always_comb begin
        state_d   = state_q;
        rsp_d     = '0;
        cnt_d     = cnt_q;
        undef_d   = undef_q;
        issue     = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (in_win && req.write && arith) begin
                    if (!hazard && free) begin
                        issue       = 1'b1;
                        rsp_d.ready = 1'b1;
                        state_d     = S_ACK;
                    end
                end else if (in_win && !req.write && opc == OPC_STORE) begin
                    state_d = S_DRAIN;
                end else if (in_win) begin
                    undef_d     = 1'b1; // read of a non-store, or a write of a non-arithmetic opcode
                    rsp_d.ready = 1'b1;
                    state_d     = S_ACK;
                end
            end
            S_ACK: begin
                state_d = S_IDLE; // host still holds the request here and drops it in the next cycle
            end
            S_DRAIN: begin
                if (idle_all) begin
                    cnt_d   = LAT_STORE - 4'h1;
                    state_d = S_STORE;
                end
            end
            S_STORE: begin
                if (cnt_q == 4'h0) begin
                    rsp_d.ready = 1'b1;
                    rsp_d.rdata = reg_q[dst];
                    state_d     = S_ACK;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            rsp_q   <= '0;
            cnt_q   <= 4'h0;
            undef_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rsp_q   <= rsp_d;
            cnt_q   <= cnt_d;
            undef_q <= undef_d;
        end
    end

    // execution slots: count down, retire into the register file or compare flags, then take the new issue
    always_comb begin
        reg_d = reg_q;
        cmp_d = cmp_q;
        for (int i = 0; i < NSLOT; i++) begin
            slot_d[i] = slot_q[i];
            if (slot_q[i].valid) begin
                if (slot_q[i].cnt == 4'h0) begin
                    slot_d[i].valid = 1'b0;
                    if (slot_q[i].is_cmp) begin
                        cmp_d = slot_q[i].res[1:0];
                    end else begin
                        reg_d[slot_q[i].dst] = slot_q[i].res;
                    end
                end else begin
                    slot_d[i].cnt = slot_q[i].cnt - 4'h1;
                end
            end
        end
        // a slot freed this cycle is not reused until the next, which costs one cycle at most
        if (issue) begin
            slot_d[free_idx] = '{valid: 1'b1, is_cmp: opc == OPC_CMP, dst: dst,
                                 cnt: lat - 4'h1, res: res};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_q <= CMP_RESET;
            for (int i = 0; i < NSLOT; i++) begin
                slot_q[i] <= '0;
            end
            for (int i = 0; i < NREG; i++) begin
                reg_q[i] <= FP_ZERO;
            end
        end else begin
            cmp_q  <= cmp_d;
            slot_q <= slot_d;
            reg_q  <= reg_d;
        end
    end

    assign rsp       = rsp_q;
    assign cmp_flags = cmp_q;
    assign undef_op  = undef_q;
endmodule // fp_issue_port
